/* sfb_core.sv */
// serial flash command core: buffer read and write, page read, program and erase
`timescale 1ns/1ps
`default_nettype none
module sfb_core #(
   parameter int BUF_BYTES  = 264,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // serial pins
   input  wire logic        cs_n,
   input  wire logic        sck,
   input  wire logic        si,
   output logic             so,
   output logic             so_oe,
   // configuration pin
   input  wire logic        page_256,
   // status
   output logic             busy,
   // array read port
   output logic             arr_rd_en,
   output logic [10:0]      arr_rd_page,
   output logic [8:0]       arr_rd_byte,
   input  wire logic [7:0]  arr_rd_data,
   // array program and erase port
   output logic             arr_erase,
   output logic             arr_prog,
   output logic [10:0]      arr_page,
   output logic             arr_wr_valid,
   output logic [7:0]       arr_wr_data,
   input  wire logic        arr_wr_ready,
   input  wire logic        arr_done
);
   typedef enum { S_OP, S_ADDR, S_DUMMY, S_RD, S_WR, S_IGN } sfb_st_t;
   typedef enum { P_IDLE, P_ERASE, P_LOAD, P_WAIT } sfb_pe_t;

   // ----------------------------------------------------------------
   // pin synchronisers, bit 0 feeds only bit 1
   // ----------------------------------------------------------------
   logic [2:0] cs_q;
   logic [2:0] sck_q;
   logic [1:0] si_q;
   logic [1:0] p256_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cs_q   <= sfb_pkg::CS_SYNC_RST;
         sck_q  <= sfb_pkg::PIN_SYNC_RST;
         si_q   <= sfb_pkg::PIN_SYNC_RST[1:0];
         p256_q <= sfb_pkg::PIN_SYNC_RST[1:0];
      end else begin
         cs_q   <= {cs_q[1:0], cs_n};
         sck_q  <= {sck_q[1:0], sck};
         si_q   <= {si_q[0], si};
         p256_q <= {p256_q[0], page_256};
      end
   end

   wire cs_high  = cs_q[1];
   wire cs_rise  = cs_q[1] && !cs_q[2];
   wire sck_rise = sck_q[1] && !sck_q[2] && !cs_high; // R21
   wire sck_fall = !sck_q[1] && sck_q[2] && !cs_high; // R21
   wire p256     = p256_q[1];

   // ----------------------------------------------------------------
   // frame registers
   // ----------------------------------------------------------------
   sfb_st_t          st_q;
   sfb_pkg::sfb_cmd_t cmd_q;
   logic             bank_q;
   logic [2:0]       bit_q;
   logic [2:0]       cnt_q;
   logic [7:0]       rx_q;
   logic [15:0]      addr_q;
   logic [8:0]       idx_q;
   logic [10:0]      page_q;
   logic             armed_q;
   logic [2:0]       obit_q;
   logic [6:0]       tx_q;
   logic             so_q;
   logic             so_oe_q;
   logic             rd_en_q;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire [7:0]  rx_d      = {rx_q[6:0], si_q[1]}; // R21
   wire        byte_done = sck_rise && (bit_q == 3'h7);
   wire [23:0] addr_d    = {addr_q, rx_d};
   wire [8:0]  bidx_w    = p256 ? {1'b0, addr_d[7:0]} : addr_d[8:0]; // R6
   wire [10:0] page_w    = p256 ? addr_d[18:8] : addr_d[19:9]; // R14
   wire [8:0]  last_w    = p256 ? sfb_pkg::BUF_LAST_256 : sfb_pkg::BUF_LAST_264;
   wire [8:0]  idx_nx    = sfb_pkg::next_idx(idx_q, p256);
   wire        op_end    = byte_done && (st_q == S_OP);
   wire        addr_end  = byte_done && (st_q == S_ADDR) && (cnt_q[1:0] == sfb_pkg::ADDR_LAST);
   wire        is_array  = (cmd_q == sfb_pkg::CMD_PAGE_RD) || (cmd_q == sfb_pkg::CMD_PROG) ||
                           (cmd_q == sfb_pkg::CMD_PROG_ERASE) || (cmd_q == sfb_pkg::CMD_ERASE);
   wire [2:0]  dummy_w   = (cmd_q == sfb_pkg::CMD_PAGE_RD) ? sfb_pkg::DUMMY_PAGE_RD
                                                           : sfb_pkg::DUMMY_BUF_RD;
   wire        hdr_end   = byte_done && (st_q == S_DUMMY) && (cnt_q == dummy_w - 3'h1);
   wire        sram_we   = byte_done && (st_q == S_WR); // R11
   wire        tx_step   = sck_fall && (st_q == S_RD);
   wire        tx_load   = tx_step && (obit_q == 3'h0);
   wire        launch    = cs_rise && armed_q;
   logic [7:0] buf_rd;
   logic [7:0] buf_prog;
   wire [7:0]  src_w     = (cmd_q == sfb_pkg::CMD_PAGE_RD) ? arr_rd_data : buf_rd; // R3
   sfb_pe_t    pe_q;
   logic       busy_q;

   sfb_st_t st_d;
   always_comb begin
      st_d = st_q;
      if (op_end) begin
         case (sfb_pkg::cmd_class(rx_d))
            sfb_pkg::CMD_NONE: st_d = S_IGN;
            sfb_pkg::CMD_BUF_RD, sfb_pkg::CMD_BUF_WR: st_d = S_ADDR; // R20
            default: st_d = busy_q ? S_IGN : S_ADDR;
         endcase
      end else if (addr_end) begin
         case (cmd_q)
            sfb_pkg::CMD_BUF_RD, sfb_pkg::CMD_PAGE_RD: st_d = S_DUMMY; // R7
            sfb_pkg::CMD_BUF_WR: st_d = S_WR; // R11
            default: st_d = S_IGN;
         endcase
      end else if (hdr_end) begin
         st_d = S_RD; // R7
      end
   end

   // ----------------------------------------------------------------
   // receive side
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_q   <= S_OP;
         cmd_q  <= sfb_pkg::CMD_NONE;
         bank_q <= 1'b0;
         bit_q  <= 3'h0;
         cnt_q  <= 3'h0;
         rx_q   <= 8'h00;
         addr_q <= 16'h0000;
         page_q <= 11'h000;
      end else if (cs_high) begin
         st_q  <= S_OP; // R2 R12
         bit_q <= 3'h0;
         cnt_q <= 3'h0;
      end else if (sck_rise) begin
         st_q  <= st_d;
         bit_q <= bit_q + 3'h1;
         rx_q  <= rx_d;
         if (op_end) begin
            cmd_q  <= sfb_pkg::cmd_class(rx_d);
            bank_q <= sfb_pkg::op_bank(rx_d);
         end
         if (byte_done && (st_q == S_ADDR)) begin
            addr_q <= addr_d[15:0];
         end
         if (addr_end) begin
            page_q <= page_w; // R14
         end
         if (byte_done) begin
            cnt_q <= (addr_end || op_end) ? 3'h0 : cnt_q + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // buffer index, transmit shifter and launch arming
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         idx_q   <= 9'h000;
         obit_q  <= 3'h0;
         tx_q    <= 7'h00;
         so_q    <= sfb_pkg::SO_RST;
         so_oe_q <= 1'b0;
         armed_q <= 1'b0;
         rd_en_q <= 1'b0;
      end else begin
         rd_en_q <= !cs_high && (cmd_q == sfb_pkg::CMD_PAGE_RD) && (st_q != S_OP); // R3
         if (cs_high) begin
            so_oe_q <= 1'b0; // R2
            armed_q <= 1'b0;
         end else if (addr_end) begin
            idx_q   <= bidx_w; // R6
            obit_q  <= 3'h0;
            armed_q <= is_array && (cmd_q != sfb_pkg::CMD_PAGE_RD); // R14
         end else if (sram_we) begin
            idx_q <= idx_nx; // R11 R12
         end else if (tx_load) begin
            so_q    <= src_w[7]; // R21
            tx_q    <= src_w[6:0];
            obit_q  <= 3'h7;
            idx_q   <= idx_nx; // R1 R9
            so_oe_q <= 1'b1;
         end else if (tx_step) begin
            so_q   <= tx_q[6];
            tx_q   <= {tx_q[5:0], 1'b0};
            obit_q <= obit_q - 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // self-timed program and erase
   // ----------------------------------------------------------------
   logic [10:0] pg_q;
   logic        pbank_q;
   logic [8:0]  fidx_q;
   logic        do_prog_q;
   logic        erase_q;
   logic        prog_q;
   logic        push_rdy;
   wire         push     = (pe_q == P_LOAD);
   wire         push_acc = push && push_rdy;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pe_q      <= P_IDLE;
         busy_q    <= 1'b0;
         pg_q      <= 11'h000;
         pbank_q   <= 1'b0;
         fidx_q    <= 9'h000;
         do_prog_q <= 1'b0;
         erase_q   <= 1'b0;
         prog_q    <= 1'b0;
      end else begin
         erase_q <= 1'b0;
         prog_q  <= 1'b0;
         case (pe_q)
            P_IDLE: if (launch) begin
               pg_q      <= page_q;
               pbank_q   <= bank_q;
               busy_q    <= 1'b1; // R19
               fidx_q    <= 9'h000;
               do_prog_q <= (cmd_q == sfb_pkg::CMD_PROG_ERASE);
               if (cmd_q == sfb_pkg::CMD_PROG) begin
                  prog_q <= 1'b1; // R16
                  pe_q   <= P_LOAD;
               end else begin
                  erase_q <= 1'b1; // R15 R18
                  pe_q    <= P_ERASE;
               end
            end
            P_ERASE: if (arr_done) begin
               if (do_prog_q) begin
                  prog_q <= 1'b1; // R15
                  pe_q   <= P_LOAD;
               end else begin
                  busy_q <= 1'b0;
                  pe_q   <= P_IDLE;
               end
            end
            P_LOAD: if (push_acc) begin
               fidx_q <= sfb_pkg::next_idx(fidx_q, p256);
               if (fidx_q == last_w) pe_q <= P_WAIT;
            end
            P_WAIT: if (arr_done) begin
               busy_q <= 1'b0; // R19
               pe_q   <= P_IDLE;
            end
            default: pe_q <= P_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // storage and program data path
   // ----------------------------------------------------------------
   sfb_sram #(.WIDTH(8), .DEPTH(BUF_BYTES)) u_sram (
      .clk   (ref_clk),
      .we    (sram_we),
      .wbank (bank_q),
      .widx  (idx_q),
      .wdata (rx_d),
      .abank (bank_q),
      .aidx  (idx_q),
      .adata (buf_rd),
      .bbank (pbank_q),
      .bidx  (fidx_q),
      .bdata (buf_prog)
   );

   // array may stall the stream; the loader waits on the fifo
   sfb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (ref_clk),
      .nrst      (nrst),
      .in_valid  (push),
      .in_ready  (push_rdy),
      .in_data   (buf_prog),
      .out_valid (arr_wr_valid),
      .out_ready (arr_wr_ready),
      .out_data  (arr_wr_data)
   );

   assign so          = so_q;
   assign so_oe       = so_oe_q;
   assign busy        = busy_q;
   assign arr_rd_en   = rd_en_q;
   assign arr_rd_page = page_q;
   assign arr_rd_byte = idx_q;
   assign arr_erase   = erase_q;
   assign arr_prog    = prog_q;
   assign arr_page    = pg_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   so_release_a: assert property (cs_high |=> !so_oe_q) // R2
      else $error("serial output still driven after chip select high");
   page_wrap_a: assert property (tx_load && cmd_q == sfb_pkg::CMD_PAGE_RD && idx_q == last_w
      |=> idx_q == 9'h000) // R1
      else $error("page read did not wrap to byte zero");
   buf_wrap_a: assert property (tx_load && cmd_q == sfb_pkg::CMD_BUF_RD && idx_q == last_w
      |=> idx_q == 9'h000) // R9
      else $error("buffer read did not wrap to byte zero");
   wr_wrap_a: assert property (sram_we && idx_q == last_w |=> idx_q == 9'h000) // R12
      else $error("buffer write did not wrap to byte zero");
   page_rd_keep_a: assert property (cmd_q == sfb_pkg::CMD_PAGE_RD |-> !sram_we) // R3
      else $error("page read wrote a buffer");
   first_bit_a: assert property ($rose(so_oe_q) |-> st_q == S_RD && $past(sck_fall)) // R7
      else $error("data driven before header complete");
   busy_set_a: assert property (launch |=> busy_q ##1 busy_q) // R19
      else $error("busy not raised on launch");
   erase_first_a: assert property (launch && cmd_q == sfb_pkg::CMD_PROG_ERASE
      |=> erase_q && !prog_q && pe_q == P_ERASE) // R15
      else $error("program with erase did not erase first");
   prog_only_a: assert property (launch && cmd_q == sfb_pkg::CMD_PROG
      |=> prog_q && !erase_q) // R16
      else $error("program without erase issued an erase");
   erase_end_a: assert property (pe_q == P_ERASE && arr_done && !do_prog_q
      |=> !busy_q && !prog_q) // R18
      else $error("page erase did not finish cleanly");

   buf_read_c:  cover property (tx_load && cmd_q == sfb_pkg::CMD_BUF_RD);
   buf_write_c: cover property (sram_we ##[1:200] cs_rise);
   prog_c:      cover property (launch && cmd_q == sfb_pkg::CMD_PROG_ERASE);
   erase_c:     cover property (launch && cmd_q == sfb_pkg::CMD_ERASE);
endmodule : sfb_core
`default_nettype wire

/* sfb_pkg.sv */
// shared constants, opcodes and helper functions for the serial flash buffer core
//
// Contract
// (R1) page read wraps from the page's last byte to byte zero of the same page
// (R2) chip select rising ends any read and releases the serial output
// (R3) page read takes bytes from the array and leaves both buffers alone
// (R4) opcodes d4 and d1 read buffer 1, d6 and d3 read buffer 2
// (R5) host uses d1 or d3 only at or below the low rate clock limit
// (R6) buffer commands carry a 9-bit or 8-bit buffer index in the low address bits
// (R7) buffer read needs one don't-care byte after the address before data comes out
// (R8) host holds chip select low from opcode until the last wanted data bit
// (R9) buffer read wraps from the buffer's last byte to byte zero while clocking goes on
// (R10) opcode 84 loads buffer 1, opcode 87 loads buffer 2
// (R11) buffer write stores bytes from the addressed location onward, one by one
// (R12) buffer write wraps to byte zero and loads until chip select rises
// (R13) opcodes 83 and 86 program buffer 1 or 2 with built-in erase
// (R14) program and erase carry an 11-bit page number placed per page size mode
// (R15) program with erase erases the page, then programs it, as one self-timed job
// (R16) opcodes 88 and 89 program buffer 1 or 2 without erasing first
// (R17) host erases the page before using program without erase
// (R18) opcode 81 erases the addressed page to all ones, self-timed
// (R19) busy is reported while any program or erase job runs
// (R20) buffers are read and written without touching the flash array
// (R21) bytes travel msb first, sampled on clock rise, driven on clock fall
`default_nettype none
package sfb_pkg;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_PAGE_RD    = 8'hd2;
   localparam logic [7:0] OP_BUF1_RD_HI = 8'hd4;
   localparam logic [7:0] OP_BUF1_RD_LO = 8'hd1;
   localparam logic [7:0] OP_BUF2_RD_HI = 8'hd6;
   localparam logic [7:0] OP_BUF2_RD_LO = 8'hd3;
   localparam logic [7:0] OP_BUF1_WR    = 8'h84;
   localparam logic [7:0] OP_BUF2_WR    = 8'h87;
   localparam logic [7:0] OP_BUF1_PGE   = 8'h83;
   localparam logic [7:0] OP_BUF2_PGE   = 8'h86;
   localparam logic [7:0] OP_BUF1_PG    = 8'h88;
   localparam logic [7:0] OP_BUF2_PG    = 8'h89;
   localparam logic [7:0] OP_PAGE_ERASE = 8'h81;

   // ----------------------------------------------------------------
   // counts, limits and reset values
   // ----------------------------------------------------------------
   localparam logic [8:0] BUF_LAST_264  = 9'h107;
   localparam logic [8:0] BUF_LAST_256  = 9'h0ff;
   localparam logic [1:0] ADDR_LAST     = 2'h2;
   localparam logic [2:0] DUMMY_BUF_RD  = 3'h1;
   localparam logic [2:0] DUMMY_PAGE_RD = 3'h4;
   localparam logic [2:0] CS_SYNC_RST   = 3'h7;
   localparam logic [2:0] PIN_SYNC_RST  = 3'h0;
   localparam logic       SO_RST        = 1'b0;

   typedef enum {
      CMD_NONE, CMD_BUF_RD, CMD_BUF_WR, CMD_PAGE_RD, CMD_PROG_ERASE, CMD_PROG, CMD_ERASE
   } sfb_cmd_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic sfb_cmd_t cmd_class(input logic [7:0] op);
      case (op)
         OP_BUF1_RD_HI, OP_BUF1_RD_LO, OP_BUF2_RD_HI, OP_BUF2_RD_LO: return CMD_BUF_RD; // R4
         OP_BUF1_WR, OP_BUF2_WR:       return CMD_BUF_WR; // R10
         OP_PAGE_RD:                   return CMD_PAGE_RD;
         OP_BUF1_PGE, OP_BUF2_PGE:     return CMD_PROG_ERASE; // R13
         OP_BUF1_PG, OP_BUF2_PG:       return CMD_PROG; // R16
         OP_PAGE_ERASE:                return CMD_ERASE; // R18
         default:                      return CMD_NONE;
      endcase
   endfunction : cmd_class

   function automatic logic op_bank(input logic [7:0] op);
      return (op == OP_BUF2_RD_HI) || (op == OP_BUF2_RD_LO) || (op == OP_BUF2_WR) ||
             (op == OP_BUF2_PGE) || (op == OP_BUF2_PG); // R4
   endfunction : op_bank

   // shared by buffer read, buffer write, page read and program streaming
   function automatic logic [8:0] next_idx(input logic [8:0] i, input logic p256);
      logic [8:0] last;
      last = p256 ? BUF_LAST_256 : BUF_LAST_264;
      return (i == last) ? 9'h000 : i + 9'h001;
   endfunction : next_idx

endpackage : sfb_pkg
`default_nettype wire

/* sfb_fifo.sv */
// small flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   logic [PW:0]      cnt_d;
   logic             valid_q;
   wire              push = in_valid && in_ready;
   wire              pop  = valid_q && out_ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : bump

   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = valid_q;
   assign out_data  = mem_q[rd_q];
   assign cnt_d     = cnt_q + (PW+1)'(push) - (PW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         valid_q <= 1'b0;
      end else begin
         if (push) wr_q <= bump(wr_q);
         if (pop)  rd_q <= bump(rd_q);
         cnt_q   <= cnt_d;
         valid_q <= (cnt_d != '0);
      end
   end
endmodule : sfb_fifo
`default_nettype wire

/* sfb_sram.sv */
// two data buffers in flops, one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module sfb_sram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 264
) (
   // clock
   input  wire logic             clk,
   // write port
   input  wire logic             we,
   input  wire logic             wbank,
   input  wire logic [8:0]       widx,
   input  wire logic [WIDTH-1:0] wdata,
   // read port a
   input  wire logic             abank,
   input  wire logic [8:0]       aidx,
   output logic [WIDTH-1:0]      adata,
   // read port b
   input  wire logic             bbank,
   input  wire logic [8:0]       bidx,
   output logic [WIDTH-1:0]      bdata
);
   localparam int AW = $clog2(2 * DEPTH);

   logic [WIDTH-1:0] mem_q [2 * DEPTH];

   function automatic logic [AW-1:0] loc(input logic bank, input logic [8:0] idx);
      return bank ? AW'(idx) + AW'(DEPTH) : AW'(idx);
   endfunction : loc

   assign adata = mem_q[loc(abank, aidx)];
   assign bdata = mem_q[loc(bbank, bidx)];

   // no reset: buffer contents are undefined at power up
   always_ff @(posedge clk) begin
      if (we) begin
         mem_q[loc(wbank, widx)] <= wdata;
      end
   end
endmodule : sfb_sram
`default_nettype wire

/* sfb_host.sv */
// host side model: drives the serial frame pins and samples serial output
`timescale 1ns/1ps
`default_nettype none
module sfb_host (
   // clock
   input  wire logic ref_clk,
   // serial pins
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   // one byte each way, 800 ns bit time; sck idles low outside frames
   task automatic xb(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         si = d[i];
         cyc(4);
         sck  = 1'b1;
         q[i] = so;
         cyc(4);
         sck = 1'b0;
      end
   endtask : xb
   // cs held low from opcode to last wanted bit
   task automatic hdr(input logic [7:0] op, input logic [23:0] a);
      logic [7:0] q;
      cs_n = 1'b0;
      cyc(4);
      xb(op, q);
      xb(a[23:16], q);
      xb(a[15:8], q);
      xb(a[7:0], q);
   endtask : hdr
   // released data line shows the inverse so a stale value cannot pass
   task automatic fin();
      cyc(4);
      cs_n = 1'b1;
      si   = ~si;
      cyc(8);
   endtask : fin
endmodule : sfb_host
`default_nettype wire

/* serial_flash_buffer_page_ops_test.sv */
// self-checking bench for the serial flash command core
`timescale 1ns/1ps
`default_nettype none
module serial_flash_buffer_page_ops_test;
   logic ref_clk = 1'b0, nrst = 1'b0, page_256 = 1'b0, arr_wr_ready = 1'b0, arr_done = 1'b0;
   logic cs_n, sck, si, so, so_oe, busy, arr_rd_en, arr_erase, arr_prog, arr_wr_valid;
   logic [10:0] arr_rd_page, arr_page;
   logic [8:0]  arr_rd_byte;
   logic [7:0]  arr_rd_data = 8'h00, arr_wr_data, q;
   logic [7:0]  wr_q[$];
   int n_mismatch = 0, n_tests = 0, n_er = 0, n_pg = 0, dly = 0, t = 0;
   always #50 ref_clk = ~ref_clk;
   sfb_core dut (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
      .so_oe(so_oe), .page_256(page_256), .busy(busy), .arr_rd_en(arr_rd_en),
      .arr_rd_page(arr_rd_page), .arr_rd_byte(arr_rd_byte), .arr_rd_data(arr_rd_data),
      .arr_erase(arr_erase), .arr_prog(arr_prog), .arr_page(arr_page),
      .arr_wr_valid(arr_wr_valid), .arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready),
      .arr_done(arr_done));
   // undriven output reads inverted so a stale bit cannot pass
   sfb_host host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si),
      .so(so_oe ? so : ~so));
   // ----------------------------------------------------------------
   // array model: stalls one cycle in three, ends each phase a few cycles late
   // ----------------------------------------------------------------
   function automatic logic [7:0] arr_val(input logic [10:0] p, input logic [8:0] b);
      return b[7:0] ^ {p[4:0], 3'h5};
   endfunction : arr_val
   always @(negedge ref_clk) begin
      t++;
      arr_wr_ready <= (t % 3 != 0);
      arr_rd_data  <= arr_val(arr_rd_page, arr_rd_byte);
   end
   always @(posedge ref_clk) begin
      arr_done <= 1'b0;
      if (arr_erase === 1'b1) begin n_er++; dly = 6; end
      if (arr_prog === 1'b1) n_pg++;
      if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1) begin
         wr_q.push_back(arr_wr_data);
         if (wr_q.size() % 264 == 0) dly = 6;
      end
      if (dly > 0) begin dly--; if (dly == 0) arr_done <= 1'b1; end
   end
   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input logic [95:0] s, input logic [95:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic summarize();
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic wait_idle();
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge ref_clk);
      if (busy !== 1'b0) begin n_mismatch++; summarize(); end
   endtask : wait_idle
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_buf();
      logic [7:0] rop[4] = '{8'hd4, 8'hd1, 8'hd6, 8'hd3};
      host.hdr(8'h84, 24'h000107);
      host.xb(8'ha5, q);
      host.xb(8'h3c, q);
      host.fin();
      host.hdr(8'h87, 24'h000107);
      host.xb(8'h5a, q);
      host.xb(8'hc3, q);
      host.fin();
      // slow opcodes d1/d3 are fine at this link rate
      for (int k = 0; k < 4; k++) begin
         host.hdr(rop[k], 24'h7fe107);
         host.xb(8'h00, q);
         host.xb(8'h00, q);
         chk(q, k < 2 ? 8'ha5 : 8'h5a);
         host.xb(8'h00, q);
         chk(q, k < 2 ? 8'h3c : 8'hc3);
         host.fin();
         chk(so_oe, 1'b0);
      end
      chk(n_er + n_pg, 0);
   endtask : t_buf
   task automatic t_prog();
      host.hdr(8'h83, 24'h080a00);
      host.fin();
      chk(busy, 1'b1);
      wait_idle();
      chk({n_er, n_pg}, {32'd1, 32'd1});
      chk(arr_page, 11'h405);
      chk({wr_q[0], wr_q[263]}, 16'h3ca5);
      host.hdr(8'h81, 24'h000e00);
      host.fin();
      wait_idle();
      chk({n_er, n_pg, arr_page}, {32'd2, 32'd1, 11'h007});
      host.hdr(8'h89, 24'h000e00);
      host.fin();
      wait_idle();
      chk({n_er, n_pg}, {32'd2, 32'd2});
      chk({wr_q[264], wr_q[527]}, 16'hc35a);
   endtask : t_prog
   task automatic t_page();
      host.hdr(8'hd2, 24'h000707);
      chk(arr_rd_en, 1'b1);
      repeat (4) host.xb(8'h00, q);
      host.xb(8'h00, q);
      chk(q, arr_val(11'h003, 9'h107));
      host.xb(8'h00, q);
      chk(q, arr_val(11'h003, 9'h000));
      host.fin();
      chk(so_oe, 1'b0);
      host.hdr(8'hd4, 24'h000107);
      chk(arr_rd_en, 1'b0);
      repeat (2) host.xb(8'h00, q);
      chk(q, 8'ha5);
      host.fin();
   endtask : t_page
   task automatic t_256();
      page_256 = 1'b1;
      host.cyc(4);
      host.hdr(8'h84, 24'h7ffeff);
      host.xb(8'h11, q);
      host.xb(8'h22, q);
      host.fin();
      host.hdr(8'hd1, 24'h0001ff);
      repeat (2) host.xb(8'h00, q);
      chk(q, 8'h11);
      host.xb(8'h00, q);
      chk(q, 8'h22);
      host.fin();
      host.hdr(8'hd2, 24'h0305ff);
      repeat (5) host.xb(8'h00, q);
      chk(q, arr_val(11'h305, 9'h0ff));
      host.xb(8'h00, q);
      chk(q, arr_val(11'h305, 9'h000));
      host.fin();
      chk(arr_rd_en, 1'b0);
   endtask : t_256
   initial begin
      repeat (4) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (8) @(negedge ref_clk);
      t_buf();
      t_prog();
      t_page();
      t_256();
      summarize();
   end
endmodule : serial_flash_buffer_page_ops_test
`default_nettype wire
